// ==== pkg/ndc_pkg.sv ====
package ndc_pkg;

  // Geometry
  localparam int ADDR_W       = 20;
  localparam int PIN_ADDR_W   = 10;
  localparam int ROWS         = 512;
  localparam int ROW_CNT_W    = 9;
  localparam int NIBBLE_BEATS = 4;
  localparam int INIT_REFS    = 8;
  localparam int SYNC_STAGES  = 3;

  // Clock
  localparam int CLK_PERIOD_NS = 10;

  // Device timing, ns (fastest grade)
  localparam int T_RAH_NS    = 10;
  localparam int T_RCD_NS    = 20;
  localparam int T_RAC_NS    = 70;
  localparam int T_CAC_NS    = 25;
  localparam int T_CAS_NS    = 25;
  localparam int T_RAS_NS    = 70;
  localparam int T_RP_NS     = 60;
  localparam int T_RC_NS     = 140;
  localparam int T_WP_NS     = 15;
  localparam int T_CHR_NS    = 15;
  localparam int T_NC_NS     = 50;
  localparam int T_NPA_NS    = 40;
  localparam int T_REF_NS    = 8_200_000;
  localparam int T_PAUSE_NS  = 200_000;

  function automatic int ceil_cyc(input int ns);
    return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // Derived cycle counts
  localparam int C_RAH     = ceil_cyc(T_RAH_NS);
  localparam int C_RCD     = ceil_cyc(T_RCD_NS);
  localparam int C_CAS     = ceil_cyc(T_CAS_NS);
  localparam int C_WP      = ceil_cyc(T_WP_NS);
  localparam int C_CHR     = ceil_cyc(T_CHR_NS);
  localparam int C_RP      = ceil_cyc(T_RP_NS);
  localparam int C_RAS_MIN = max2(ceil_cyc(T_RAS_NS), ceil_cyc(T_RC_NS) - C_RP);
  localparam int C_NCP     = max2(1, ceil_cyc(T_NC_NS) - C_CAS);
  // The agree register behind the flops adds one more cycle before read data is usable
  localparam int C_RD_LOW  = max2(ceil_cyc(T_RAC_NS) - C_RCD, ceil_cyc(T_CAC_NS)) + SYNC_STAGES + 1;
  localparam int C_NIB_LOW = max2(ceil_cyc(T_NPA_NS) - C_NCP, ceil_cyc(T_CAC_NS)) + SYNC_STAGES + 1;
  localparam int C_REF_ROW = T_REF_NS / (ROWS * CLK_PERIOD_NS);
  localparam int C_PAUSE   = T_PAUSE_NS / CLK_PERIOD_NS;

  // Request opcodes
  localparam logic [2:0] OP_READ      = 3'h0;
  localparam logic [2:0] OP_WRITE     = 3'h1;
  localparam logic [2:0] OP_RMW       = 3'h2;
  localparam logic [2:0] OP_NIB_READ  = 3'h3;
  localparam logic [2:0] OP_NIB_WRITE = 3'h4;

  typedef enum logic [10:0] {
    ST_INIT     = 11'h001,
    ST_IDLE     = 11'h002,
    ST_ROW      = 11'h004,
    ST_RCD      = 11'h008,
    ST_CAS      = 11'h010,
    ST_WE_LOW   = 11'h020,
    ST_CAS_UP   = 11'h040,
    ST_RAS_HOLD = 11'h080,
    ST_PRE      = 11'h100,
    ST_CBR_CAS  = 11'h200,
    ST_REF_RAS  = 11'h400
  } ndc_state_e;

endpackage

// ==== design/ndc_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module ndc_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // Pin side
  input  wire logic pin_i,
  // Synchronised level
  output var  logic level_o
);

  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Only an agreed change passes, which rejects a single-cycle glitch
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      level_o <= 1'b0;
    end else if (s2 == s3) begin
      level_o <= s3;
    end
  end

endmodule

`default_nettype wire

// ==== design/ndc_ctrl.sv ====
// Contract
// [RULE_01] One megabit array addressed by twenty bits, sent as row then column halves.
// [RULE_02] Device latches row on row strobe fall, column on column strobe fall.
// [RULE_03] Controller holds address stable before each strobe falls.
// [RULE_04] Column address may be presented right after row address hold time.
// [RULE_05] Write enable low selects write, high selects read; reads ignore data in.
// [RULE_06] Device latches data on the later of column strobe or write enable fall.
// [RULE_07] Early write: write enable low before column strobe; data valid at that edge.
// [RULE_08] Delayed write or read-modify-write: data sampled on write enable fall.
// [RULE_09] Read data keeps the polarity it was written with.
// [RULE_10] Data output undriven until column strobe goes low.
// [RULE_11] Read access limited by row strobe, column strobe or column address timing.
// [RULE_12] All 512 rows refreshed within 8.2 ms. The controller drops a refresh tick that comes when the sequencer was not idle the cycle before.
// [RULE_13] Refresh by row-strobe-only, counter refresh, or hidden refresh. The controller never issues hidden refresh.
// [RULE_14] Nibble bursts and read-modify-write supported, nibble cycle time respected.
// [RULE_15] Shared data wire users issue early writes to avoid contention.
// [RULE_16] After power-up: 200 us pause with strobes high, then eight refresh cycles.
// [RULE_17] Write enable low before column strobe keeps output undriven all cycle.
// [RULE_18] Following nibble bits are timed from the column strobe rising edge.
// [RULE_19] Extra column strobe pulses in nibble mode step through four bits cyclically.
// [RULE_20] Every strobe interval meets its minimum and maximum before release.
`timescale 1ns/1ps
`default_nettype none

module ndc_ctrl #(
  parameter int PAUSE_CYCLES = ndc_pkg::C_PAUSE
) (
  // Clock and reset
  input  wire logic                            clk_i,
  input  wire logic                            reset_n_i,
  // Configuration
  input  wire logic                            use_counter_refresh_i,
  // Request port
  input  wire logic                            req_valid_i,
  output var  logic                            req_ready_o,
  input  wire logic [2:0]                      req_op_i,
  input  wire logic [ndc_pkg::ADDR_W-1:0]      req_addr_i,
  input  wire logic [ndc_pkg::NIBBLE_BEATS-1:0] req_wdata_i,
  // Response port
  output var  logic                            rsp_valid_o,
  output var  logic [ndc_pkg::NIBBLE_BEATS-1:0] rsp_rdata_o,
  output var  logic                            init_done_o,
  // Memory pins
  output var  logic                            row_strobe_n_o,
  output var  logic                            col_strobe_n_o,
  output var  logic                            write_enable_n_o,
  output var  logic [ndc_pkg::PIN_ADDR_W-1:0]  mux_address_o,
  output var  logic                            data_in_o,
  input  wire logic                            data_out_i
);
  import ndc_pkg::*;

  localparam int PAUSE_W = $clog2(PAUSE_CYCLES + 1);
  localparam int REF_W   = $clog2(C_REF_ROW + 1);

  ndc_state_e               state;
  logic [7:0]               tmr;
  logic [7:0]               ras_age;
  logic [2:0]               op;
  logic [ADDR_W-1:0]        addr;
  logic [NIBBLE_BEATS-1:0]  wdata;
  logic [1:0]               beat;
  logic                     is_refresh;
  logic                     dout_sync;
  logic [PAUSE_W-1:0]       pause_cnt;
  logic                     pause_done;
  logic [3:0]               init_refs_left;
  logic [REF_W-1:0]         ref_tmr;
  logic                     ref_pending;
  logic [ROW_CNT_W-1:0]     ref_row;
  logic                     ref_start;
  logic                     is_read_op;
  logic                     is_nib_op;
  logic                     is_wr_op;

  // Device output is asynchronous to this clock
  ndc_sync u_dout_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .pin_i     (data_out_i),
    .level_o   (dout_sync)
  );

  assign is_read_op = (op == OP_READ) || (op == OP_RMW) || (op == OP_NIB_READ);
  assign is_nib_op  = (op == OP_NIB_READ) || (op == OP_NIB_WRITE);
  assign is_wr_op   = (op == OP_WRITE) || (op == OP_NIB_WRITE);
  assign ref_start  = (state == ST_IDLE) && !(req_valid_i && req_ready_o)
                      && (ref_pending || (init_refs_left != 4'h0));

  // Power-up pause with both strobes high
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pause_cnt  <= '0;
      pause_done <= 1'b0;
    end else if (!pause_done) begin
      pause_cnt  <= pause_cnt + 1'b1;
      pause_done <= (pause_cnt == PAUSE_W'(PAUSE_CYCLES - 1)); // [RULE_16]
    end
  end

  // Eight warm-up refreshes before traffic
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      init_refs_left <= 4'(INIT_REFS);
      init_done_o    <= 1'b0;
    end else begin
      if (ref_start && init_refs_left != 4'h0) begin
        init_refs_left <= init_refs_left - 4'h1; // [RULE_16]
      end
      init_done_o <= (init_refs_left == 4'h0) && (state == ST_IDLE);
    end
  end

  // Distributed refresh: one row per interval whose tick finds init_done_o high (idle last cycle), rounded down so 512 rows fit
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ref_tmr     <= '0;
      ref_pending <= 1'b0;
      ref_row     <= '0;
    end else begin
      if (ref_tmr == REF_W'(C_REF_ROW - 1)) begin
        ref_tmr <= '0;
      end else begin
        ref_tmr <= ref_tmr + 1'b1;
      end
      // A tick in the same cycle as the start keeps the request alive
      if (init_done_o && ref_tmr == REF_W'(C_REF_ROW - 1)) begin
        ref_pending <= 1'b1; // [RULE_12]
      end else if (ref_start) begin
        ref_pending <= 1'b0;
      end
      if (ref_start) begin
        ref_row <= ref_row + 1'b1;
      end
    end
  end

  // Sequencer and pins
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state            <= ST_INIT;
      tmr              <= 8'h00;
      ras_age          <= 8'h00;
      op               <= OP_READ;
      addr             <= '0;
      wdata            <= '0;
      beat             <= 2'h0;
      is_refresh       <= 1'b0;
      req_ready_o      <= 1'b0;
      rsp_valid_o      <= 1'b0;
      rsp_rdata_o      <= '0;
      row_strobe_n_o   <= 1'b1;
      col_strobe_n_o   <= 1'b1;
      write_enable_n_o <= 1'b1;
      mux_address_o    <= '0;
      data_in_o        <= 1'b0;
    end else begin
      rsp_valid_o <= 1'b0;
      if (tmr != 8'h00) begin
        tmr <= tmr - 8'h01;
      end
      if (ras_age != 8'hff) begin
        ras_age <= ras_age + 8'h01;
      end
      unique case (state)
        ST_INIT: begin
          if (pause_done) begin
            state       <= ST_IDLE;
            req_ready_o <= 1'b0;
          end
        end
        ST_IDLE: begin
          if (req_valid_i && req_ready_o) begin
            op               <= req_op_i;
            addr             <= req_addr_i;
            wdata            <= req_wdata_i;
            beat             <= 2'h0;
            is_refresh       <= 1'b0;
            req_ready_o      <= 1'b0;
            mux_address_o    <= req_addr_i[ADDR_W-1:PIN_ADDR_W]; // [RULE_01] [RULE_03]
            data_in_o        <= req_wdata_i[0];
            // Plain and nibble writes are early: output stays undriven, no contention
            write_enable_n_o <= !((req_op_i == OP_WRITE) || (req_op_i == OP_NIB_WRITE)); // [RULE_07] [RULE_15] [RULE_17]
            state            <= ST_ROW;
          end else if (ref_start) begin
            is_refresh  <= 1'b1;
            req_ready_o <= 1'b0;
            if (use_counter_refresh_i) begin
              col_strobe_n_o <= 1'b0; // [RULE_13]
              state          <= ST_CBR_CAS;
            end else begin
              mux_address_o <= {1'b0, ref_row}; // [RULE_13]
              state         <= ST_ROW;
            end
          end else begin
            req_ready_o <= (init_refs_left == 4'h0);
          end
        end
        ST_ROW: begin
          row_strobe_n_o <= 1'b0; // [RULE_02]
          ras_age        <= 8'h00;
          tmr            <= 8'(C_RCD - 1);
          state          <= is_refresh ? ST_RAS_HOLD : ST_RCD;
        end
        ST_RCD: begin
          // Flow-through latch: column may follow the row hold time at once
          if (tmr == 8'(C_RCD - C_RAH)) begin
            mux_address_o <= addr[PIN_ADDR_W-1:0]; // [RULE_04]
          end
          if (tmr == 8'h00) begin
            col_strobe_n_o <= 1'b0; // [RULE_02] [RULE_06]
            tmr            <= is_read_op ? 8'(C_RD_LOW - 1) : 8'(C_CAS - 1); // [RULE_11]
            state          <= ST_CAS;
          end
        end
        ST_CAS: begin
          if (tmr == 8'h00) begin
            if (is_read_op) begin
              // Sampled only while the column strobe is low, bit kept as is
              rsp_rdata_o[beat] <= dout_sync; // [RULE_05] [RULE_09] [RULE_10]
            end
            if (op == OP_RMW) begin
              data_in_o        <= wdata[0];
              write_enable_n_o <= 1'b0; // [RULE_08] [RULE_14]
              tmr              <= 8'(C_WP - 1);
              state            <= ST_WE_LOW;
            end else begin
              col_strobe_n_o <= 1'b1;
              if (is_nib_op && beat != 2'(NIBBLE_BEATS - 1)) begin
                beat  <= beat + 2'h1; // [RULE_19]
                tmr   <= 8'(C_NCP - 1); // [RULE_14]
                state <= ST_CAS_UP;
              end else begin
                rsp_valid_o <= is_read_op;
                state       <= ST_RAS_HOLD;
              end
            end
          end
        end
        ST_WE_LOW: begin
          if (tmr == 8'h00) begin
            col_strobe_n_o   <= 1'b1;
            write_enable_n_o <= 1'b1;
            rsp_valid_o      <= 1'b1;
            state            <= ST_RAS_HOLD;
          end
        end
        ST_CAS_UP: begin
          data_in_o <= wdata[beat];
          if (tmr == 8'h00) begin
            col_strobe_n_o <= 1'b0;
            // Next bit is timed from the rising edge just past
            tmr            <= is_read_op ? 8'(C_NIB_LOW - 1) : 8'(C_CAS - 1); // [RULE_18]
            state          <= ST_CAS;
          end
        end
        ST_CBR_CAS: begin
          row_strobe_n_o <= 1'b0; // [RULE_13]
          ras_age        <= 8'h00;
          tmr            <= 8'(C_CHR - 1);
          state          <= ST_REF_RAS;
        end
        ST_REF_RAS: begin
          if (tmr == 8'h00) begin
            col_strobe_n_o <= 1'b1;
            state          <= ST_RAS_HOLD;
          end
        end
        ST_RAS_HOLD: begin
          // Row strobe width and cycle time; a nibble burst stays far below the maximum
          if (ras_age >= 8'(C_RAS_MIN - 1)) begin
            row_strobe_n_o   <= 1'b1; // [RULE_20]
            col_strobe_n_o   <= 1'b1;
            write_enable_n_o <= 1'b1;
            tmr              <= 8'(C_RP - 1);
            state            <= ST_PRE;
          end
        end
        ST_PRE: begin
          if (tmr == 8'h00) begin
            state       <= ST_IDLE;
            req_ready_o <= (init_refs_left == 4'h0) && !ref_pending; // [RULE_20]
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== testbench/ndc_ctrl_properties.sv ====
`timescale 1ns/1ps
`default_nettype none

module ndc_ctrl_checker #(
  parameter int PAUSE_CYCLES = 20
) (
  // Clock and reset
  input wire logic                           clk_i,
  input wire logic                           reset_n_i,
  // Watched outputs
  input wire logic                           rsp_valid_o,
  input wire logic                           init_done_o,
  input wire logic                           row_strobe_n_o,
  input wire logic                           col_strobe_n_o,
  input wire logic                           write_enable_n_o,
  input wire logic [ndc_pkg::PIN_ADDR_W-1:0] mux_address_o,
  input wire logic                           data_in_o
);
  import ndc_pkg::*;
  localparam int NC_CYC  = C_CAS + C_NCP;
  // Slack covers one access that delays a due refresh
  localparam int REF_MAX = C_REF_ROW + 64;
  int   lo_cnt, hi_cnt, gap, age, falls, up;
  logic seen;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  always_ff @(posedge clk_i) begin
    lo_cnt <= (!reset_n_i || row_strobe_n_o) ? 0 : lo_cnt + 1;
    hi_cnt <= (!reset_n_i || !row_strobe_n_o) ? 0 : hi_cnt + 1;
    gap    <= !reset_n_i ? 1000 : ($fell(col_strobe_n_o) ? 1 : gap + 1);
  end

  always_ff @(posedge clk_i) begin
    age   <= (!reset_n_i || $fell(row_strobe_n_o)) ? 0 : age + 1;
    falls <= !reset_n_i ? 0 : falls + int'($fell(row_strobe_n_o));
    up    <= !reset_n_i ? 0 : up + 1;
    seen  <= reset_n_i && (seen || init_done_o);
  end

  sequence s_read_hold;
    (!col_strobe_n_o) [*6];
  endsequence

  sequence s_write_hold;
    !write_enable_n_o && $stable(data_in_o);
  endsequence

  a_ras_min_width: assert property ($rose(row_strobe_n_o) |-> lo_cnt >= C_RAS_MIN)
    else $error("row strobe low too short");
  a_ras_max_width: assert property (!row_strobe_n_o |-> lo_cnt < 10000)
    else $error("row strobe low too long");
  a_ras_precharge: assert property ($fell(row_strobe_n_o) |-> hi_cnt >= C_RP)
    else $error("row precharge too short");
  a_row_addr_stable: assert property ($fell(row_strobe_n_o) && col_strobe_n_o |-> $stable(mux_address_o))
    else $error("address moved at row strobe");
  a_col_addr_stable: assert property ($fell(col_strobe_n_o) && !row_strobe_n_o |-> $stable(mux_address_o))
    else $error("address moved at column strobe");
  a_nibble_spacing: assert property ($fell(col_strobe_n_o) && !row_strobe_n_o && !$past(row_strobe_n_o)
    |-> gap >= NC_CYC) else $error("column strobes too close");
  a_read_access: assert property ($fell(col_strobe_n_o) && !row_strobe_n_o && write_enable_n_o
    |-> s_read_hold) else $error("column strobe released before access");
  a_early_write: assert property ($fell(col_strobe_n_o) && !row_strobe_n_o && !write_enable_n_o
    |-> !$past(write_enable_n_o) ##1 s_write_hold) else $error("write not early or data moved");
  a_late_write_hold: assert property ($fell(write_enable_n_o) && !col_strobe_n_o
    |=> s_write_hold and !col_strobe_n_o) else $error("late write data not held");
  a_rsp_cas_high: assert property (rsp_valid_o |-> col_strobe_n_o)
    else $error("response before column strobe release");
  a_refresh_gap: assert property (seen |-> age < REF_MAX)
    else $error("row refresh overdue");
  a_init_pause: assert property ($fell(row_strobe_n_o) && !seen |-> up >= PAUSE_CYCLES)
    else $error("start-up pause too short");
  a_init_count: assert property ($rose(init_done_o) && !seen |-> falls == INIT_REFS)
    else $error("wrong start-up refresh count");
endmodule

bind ndc_ctrl ndc_ctrl_checker #(.PAUSE_CYCLES(PAUSE_CYCLES)) u_chk (
  .clk_i, .reset_n_i, .rsp_valid_o, .init_done_o, .row_strobe_n_o,
  .col_strobe_n_o, .write_enable_n_o, .mux_address_o, .data_in_o
);

`default_nettype wire

// ==== testbench/ndc_dram_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module ndc_dram_model #(
  parameter int ACC_NS = 25
) (
  // Strobes and address
  input  wire logic       row_strobe_n_i,
  input  wire logic       col_strobe_n_i,
  input  wire logic       write_enable_n_i,
  input  wire logic [9:0] mux_address_i,
  // Serial data
  input  wire logic       data_in_i,
  output var  logic       data_out_o
);
  logic       cells [bit [19:0]];
  logic [9:0] row, col;
  logic [1:0] beat;
  logic       cbr, rd, last;

  // Nibble beats step the top bit of each half, wrapping after four
  function automatic bit [19:0] key();
    return {row[9] ^ beat[1], row[8:0], col[9] ^ beat[0], col[8:0]};
  endfunction

  initial begin
    data_out_o = 1'b1;
    last = 1'b0;
  end

  always @(negedge row_strobe_n_i) begin
    row = mux_address_i;
    cbr = !col_strobe_n_i;
    beat = 2'h3;
  end

  always @(negedge col_strobe_n_i) begin
    if (!row_strobe_n_i && !cbr) begin
      col = mux_address_i;
      beat = beat + 2'h1;
      rd = write_enable_n_i;
      if (!rd) cells[key()] = data_in_i;
      #(ACC_NS);
      if (rd && !col_strobe_n_i) begin
        last = cells.exists(key()) ? cells[key()] : 1'b0;
        data_out_o = last;
      end
    end
  end

  // Bit taken just after the edge, inside its hold window
  always @(negedge write_enable_n_i) begin
    if (!row_strobe_n_i && !col_strobe_n_i && !cbr) begin
      #1;
      cells[key()] = data_in_i;
    end
  end

  // Released pin shows a changed level, never a stale valid bit
  always @(posedge col_strobe_n_i) data_out_o = ~last;

endmodule

`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import ndc_pkg::*;
  localparam int PAUSE = 20;
  localparam int RST_CYC = 5;

  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        use_counter_refresh_i = 1'b1;
  logic        req_valid_i = 1'b0;
  logic [2:0]  req_op_i = 3'h0;
  logic [19:0] req_addr_i = 20'h0_0000;
  logic [3:0]  req_wdata_i = 4'h0;
  logic        req_ready_o, rsp_valid_o, init_done_o, data_in_o, data_out_i;
  logic        row_strobe_n_o, col_strobe_n_o, write_enable_n_o;
  logic [9:0]  mux_address_o;
  logic [3:0]  rsp_rdata_o, rd;
  logic [3:0]  pat = 4'h5;
  logic [19:0] addr [4] = '{20'hF_FC00, 20'h0_03FF, 20'h0_0000, 20'hF_FFFF};
  int          n_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          n_ras = 0;
  int          n_cbr = 0;
  int          first_fall = 0;

  ndc_ctrl #(.PAUSE_CYCLES(PAUSE)) dut (
    .clk_i, .reset_n_i, .use_counter_refresh_i, .req_valid_i, .req_ready_o,
    .req_op_i, .req_addr_i, .req_wdata_i, .rsp_valid_o, .rsp_rdata_o, .init_done_o,
    .row_strobe_n_o, .col_strobe_n_o, .write_enable_n_o, .mux_address_o,
    .data_in_o, .data_out_i
  );

  ndc_dram_model mem (
    .row_strobe_n_i(row_strobe_n_o), .col_strobe_n_i(col_strobe_n_o),
    .write_enable_n_i(write_enable_n_o), .mux_address_i(mux_address_o),
    .data_in_i(data_in_o), .data_out_o(data_out_i)
  );

  always #5 clk_i = ~clk_i;
  always @(negedge row_strobe_n_o) n_ras++;
  always @(negedge col_strobe_n_o) if (row_strobe_n_o) n_cbr++;
  // Cycle of the first strobe activity after reset, to time the start-up pause
  always @(negedge row_strobe_n_o or negedge col_strobe_n_o) if (first_fall == 0) first_fall = cyc;

  // Run needs about 4000 cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Valid held until a rising edge sees ready; ends on a falling edge
  task automatic req(input logic [2:0] op, input logic [19:0] a, input logic [3:0] w);
    int t;
    t = 0;
    @(negedge clk_i);
    req_op_i = op;
    req_addr_i = a;
    req_wdata_i = w;
    req_valid_i = 1'b1;
    while (req_ready_o !== 1'b1 && t < 4000) begin
      @(negedge clk_i);
      t++;
    end
    @(negedge clk_i);
    req_valid_i = 1'b0;
    rd = 4'hx;
    while (op != OP_WRITE && op != OP_NIB_WRITE && rsp_valid_o !== 1'b1 && t < 4000) begin
      @(negedge clk_i);
      t++;
    end
    if (rsp_valid_o === 1'b1) rd = rsp_rdata_o;
  endtask

  task automatic rd_all();
    for (int i = 0; i < 4; i++) begin
      req(OP_READ, addr[i], 4'hF);
      chk("read bit", {3'h0, pat[i]}, {3'h0, rd[0]});
    end
  endtask

  task automatic t_init();
    int t;
    t = 0;
    while (init_done_o !== 1'b1 && t < 1000) begin
      @(negedge clk_i);
      t++;
    end
    chk("start-up refreshes", 4'(INIT_REFS), 4'(n_cbr));
    chk("start-up row strobes", 4'(INIT_REFS), 4'(n_ras));
    chk("start-up pause", 4'h1, {3'h0, first_fall > RST_CYC + PAUSE});
  endtask

  task automatic t_rw();
    for (int i = 0; i < 4; i++) req(OP_WRITE, addr[i], {3'h7, pat[i]});
    rd_all();
  endtask

  task automatic t_rmw();
    for (int i = 0; i < 2; i++) begin
      req(OP_RMW, addr[i], {3'h0, ~pat[i]});
      chk("modify old bit", {3'h0, pat[i]}, {3'h0, rd[0]});
      pat[i] = ~pat[i];
    end
    rd_all();
  endtask

  task automatic t_nib();
    // Not an alternating pattern, so stale inverted beats cannot all pass by luck
    req(OP_NIB_WRITE, 20'h5_A5A4, 4'h6);
    req(OP_NIB_READ, 20'h5_A5A4, 4'h0);
    chk("nibble bits", 4'h6, rd);
    req(OP_READ, 20'h5_A5A4, 4'h0);
    chk("nibble first bit", 4'h0, {3'h0, rd[0]});
  endtask

  task automatic t_ref();
    int c0;
    int r0;
    use_counter_refresh_i = 1'b0;
    c0 = n_cbr;
    r0 = n_ras;
    repeat (2 * C_REF_ROW + 40) @(negedge clk_i);
    chk("counter refreshes", 4'h0, 4'(n_cbr - c0));
    chk("row refreshes", 4'h1, {3'h0, (n_ras - r0) inside {2, 3}});
    rd_all();
  endtask

  initial begin
    repeat (RST_CYC) @(negedge clk_i);
    reset_n_i = 1'b1;
    t_init();
    t_rw();
    t_rmw();
    t_nib();
    t_ref();
    wrap_up();
  end
endmodule

`default_nettype wire
